// File: rtl/pin_sync.sv
// two-flop synchroniser for a group of slot pins
`timescale 1ns/1ns
`include "slot_hotplug_params.svh"
module pin_sync
  import slot_hotplug_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_out;

  // --------------------------------------------------------------------------
  // per-bit two-flop chain
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      next_stage1[i] = pin_in[i];
      next_out[i]    = stage1[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage1[i]       <= 1'b0;
        pin_sync_out[i] <= 1'b0;
      end else begin
        stage1[i]       <= next_stage1[i];
        pin_sync_out[i] <= next_out[i];
      end
    end
  end

endmodule : pin_sync

// File: rtl/slot_hotplug_control.sv
// slot control, capability and status registers of a hot-plug switch port
//
// Function
// - button press raises event when enabled
// - power fault raises event when enabled
// - latch sensor change raises event when enabled
// - presence change raises event when enabled
// - command completion raises interrupt when enabled
// - master enable gates all hot-plug interrupts
// - absent capability makes field read zero
// - reset loads fields from CTL_INIT parameter, masked by CAPS_INIT
// - attention light field sets and reads indicator
// - attention field zero without attention light
// - power light field sets and reads indicator
// - power light field zero without power light
// - upstream port power light output ignores field writes
// - power switch bit: zero on, one off
// - interlock bit reads zero, one toggles
// - link active change raises event when enabled
// - each slot control write outside a transfer is one command, flagged when done
// - slot events set sticky clear-on-one flags
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "slot_hotplug_params.svh"
module slot_hotplug_control
  import slot_hotplug_pkg::*;
#(
  parameter logic [31:0] CAPS_INIT     = `CAPS_RESET,
  parameter logic [15:0] CTL_INIT      = `CTL_INIT_RESET,
  parameter bit          UPSTREAM_PORT = 1'b0
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              button_pin,
  input  wire logic              fault_pin,
  input  wire logic              latch_open_pin,
  input  wire logic              presence_pin,
  input  wire logic              link_active,
  input  wire logic              expander_done,
  output logic                   expander_req,
  output logic      [1:0]        attention_light,
  output logic      [1:0]        power_light,
  output logic                   slot_power_off,
  output logic                   interlock_engaged,
  output logic                   hotplug_irq,
  output logic                   wake_event
);

  // --------------------------------------------------------------------------
  // field availability from capabilities
  // --------------------------------------------------------------------------
  function automatic half_t ctl_mask(input logic [31:0] caps);
    half_t m;
    m = '0;
    m[`CTL_BUTTON_EN]   = caps[`CAP_BUTTON];
    m[`CTL_FAULT_EN]    = caps[`CAP_POWER_CTL];
    m[`CTL_LATCH_EN]    = caps[`CAP_LATCH];
    m[`CTL_PRESENCE_EN] = caps[`CAP_HOTPLUG];
    m[`CTL_CMD_INT_EN]  = caps[`CAP_HOTPLUG];
    m[`CTL_MASTER_EN]   = caps[`CAP_HOTPLUG];
    m[`CTL_ATTN_HI:`CTL_ATTN_LO] = {2{caps[`CAP_ATTN_LIGHT]}};
    m[`CTL_PWRL_HI:`CTL_PWRL_LO] = {2{caps[`CAP_POWER_LIGHT]}};
    m[`CTL_POWER_SW]    = caps[`CAP_POWER_CTL];
    m[`CTL_LINK_EN]     = 1'b1;
    return m;
  endfunction : ctl_mask

  localparam half_t CTL_RESET = CTL_INIT & ctl_mask(CAPS_INIT);

  logic [31:0] caps;
  logic [31:0] next_caps;
  half_t       ctl_init;
  half_t       next_ctl_init;
  half_t       ctl;
  half_t       next_ctl;
  logic        next_interlock;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  half_t       cmask;
  half_t       ctl_rd;
  half_t       sts_rd;
  logic [31:0] lane;
  logic        wr_acc;
  logic        wr_ctl;
  logic        hit;

  assign cmask  = ctl_mask(caps);
  assign ctl_rd = ctl & cmask;
  assign pready = 1'b1;
  assign lane   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_acc = psel & penable & pwrite;
  assign wr_ctl = wr_acc & (paddr == `ADDR_W'(`ADDR_SLOT_CONTROL));

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  always_comb begin
    next_caps      = caps;
    next_ctl_init  = ctl_init;
    next_ctl       = ctl;
    next_interlock = interlock_engaged;
    if (wr_acc && paddr == `ADDR_W'(`ADDR_SLOT_CAPABILITIES)) begin
      next_caps = (pwdata & lane) | (caps & ~lane);
    end else if (wr_acc && paddr == `ADDR_W'(`ADDR_SLOT_CONTROL_INIT)) begin
      next_ctl_init = half_t'((pwdata & lane) | ({16'h0000, ctl_init} & ~lane));
    end else if (wr_ctl) begin
      next_ctl = half_t'((pwdata & lane & {16'h0000, cmask})
               | ({16'h0000, ctl} & ~(lane & {16'h0000, cmask})));
      if (pwdata[`CTL_INTERLOCK] && pstrb[1] && caps[`CAP_INTERLOCK]) begin
        next_interlock = ~interlock_engaged;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caps              <= CAPS_INIT;
      ctl_init          <= CTL_INIT;
      ctl               <= CTL_RESET;
      interlock_engaged <= 1'b0;
    end else begin
      caps              <= next_caps;
      ctl_init          <= next_ctl_init;
      ctl               <= next_ctl;
      interlock_engaged <= next_interlock;
    end
  end

  // --------------------------------------------------------------------------
  // slot outputs
  // --------------------------------------------------------------------------
  assign attention_light = ctl_rd[`CTL_ATTN_HI:`CTL_ATTN_LO];
  assign power_light     = UPSTREAM_PORT ? 2'h0 : ctl_rd[`CTL_PWRL_HI:`CTL_PWRL_LO];
  assign slot_power_off  = ctl_rd[`CTL_POWER_SW];

  // --------------------------------------------------------------------------
  // slot event detection
  // --------------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       latch_prev;
  logic       presence_prev;
  logic       link_prev;
  logic       next_latch_prev;
  logic       next_presence_prev;
  logic       next_link_prev;
  logic [8:0] ev;
  logic [8:0] flags;
  logic [8:0] next_flags;
  logic [8:0] clr;
  logic [8:0] en;

  pin_sync #(
    .WIDTH        (4)
  ) u_pin_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       ({presence_pin, latch_open_pin, fault_pin, button_pin}),
    .pin_sync_out (pins_s)
  );

  cmd_state_e cmd_state;
  cmd_state_e next_cmd_state;

  always_comb begin
    ev                     = '0;
    ev[`STS_BUTTON]        = pins_s[0];
    ev[`STS_FAULT]         = pins_s[1];
    ev[`STS_LATCH_CHG]     = pins_s[2] ^ latch_prev;
    ev[`STS_PRESENCE_CHG]  = pins_s[3] ^ presence_prev;
    ev[`STS_CMD_DONE]      = (cmd_state == CMD_DONE);
    ev[`STS_LINK_CHG]      = link_active ^ link_prev;
    clr = '0;
    if (wr_acc && paddr == `ADDR_W'(`ADDR_SLOT_STATUS)) begin
      clr = pwdata[8:0] & lane[8:0];
    end
    clr[7:5]           = 3'h0;
    next_flags         = (flags & ~clr) | ev;
    next_flags[7:5]    = 3'h0;
    next_latch_prev    = pins_s[2];
    next_presence_prev = pins_s[3];
    next_link_prev     = link_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags         <= '0;
      latch_prev    <= 1'b0;
      presence_prev <= 1'b0;
      link_prev     <= 1'b0;
    end else begin
      flags         <= next_flags;
      latch_prev    <= next_latch_prev;
      presence_prev <= next_presence_prev;
      link_prev     <= next_link_prev;
    end
  end

  // --------------------------------------------------------------------------
  // command engine: expander transfer, then completion flag
  // --------------------------------------------------------------------------
  always_comb begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      CMD_IDLE: begin
        if (wr_ctl) next_cmd_state = CMD_XFER;
      end
      CMD_XFER: begin
        if (expander_done && !wr_ctl) next_cmd_state = CMD_DONE;
      end
      CMD_DONE: begin
        next_cmd_state = wr_ctl ? CMD_XFER : CMD_IDLE;
      end
      default: next_cmd_state = CMD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_state <= CMD_IDLE;
    else          cmd_state <= next_cmd_state;
  end

  assign expander_req = (cmd_state == CMD_XFER);

  // --------------------------------------------------------------------------
  // interrupt and wake gating
  // --------------------------------------------------------------------------
  always_comb begin
    en                    = '0;
    en[`STS_BUTTON]       = ctl_rd[`CTL_BUTTON_EN];
    en[`STS_FAULT]        = ctl_rd[`CTL_FAULT_EN];
    en[`STS_LATCH_CHG]    = ctl_rd[`CTL_LATCH_EN];
    en[`STS_PRESENCE_CHG] = ctl_rd[`CTL_PRESENCE_EN];
    en[`STS_CMD_DONE]     = ctl_rd[`CTL_CMD_INT_EN];
    en[`STS_LINK_CHG]     = ctl_rd[`CTL_LINK_EN];
  end

  assign hotplug_irq = ctl_rd[`CTL_MASTER_EN] & (|(flags & en));
  assign wake_event  = |(flags & en & ~(9'h001 << `STS_CMD_DONE));

  // --------------------------------------------------------------------------
  // read path, captured in the setup phase
  // --------------------------------------------------------------------------
  always_comb begin
    sts_rd                       = half_t'({7'h00, flags});
    sts_rd[`STS_LATCH_STATE]     = pins_s[2];
    sts_rd[`STS_PRESENCE_STATE]  = pins_s[3];
    sts_rd[`STS_INTERLOCK_STATE] = interlock_engaged;
    hit          = 1'b1;
    next_prdata  = `RDATA_RESET;
    if (paddr == `ADDR_W'(`ADDR_SLOT_CAPABILITIES)) begin
      next_prdata = caps;
    end else if (paddr == `ADDR_W'(`ADDR_SLOT_CONTROL)) begin
      next_prdata = {16'h0000, ctl_rd};
    end else if (paddr == `ADDR_W'(`ADDR_SLOT_STATUS)) begin
      next_prdata = {16'h0000, sts_rd};
    end else if (paddr == `ADDR_W'(`ADDR_SLOT_CONTROL_INIT)) begin
      next_prdata = {16'h0000, ctl_init};
    end else begin
      hit = 1'b0;
    end
    next_pslverr = ~hit;
    if (!(psel && !penable)) begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `RDATA_RESET;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_ctl_setup;
  assign rd_ctl_setup = psel & ~penable & ~pwrite & (paddr == `ADDR_W'(`ADDR_SLOT_CONTROL));

  sequence s_cmd_issue;
    wr_ctl ##1 expander_req;
  endsequence
  sequence s_cmd_finish;
    (cmd_state == CMD_DONE) ##1 flags[`STS_CMD_DONE];
  endsequence

  property p_cmd_start;
    wr_ctl |-> s_cmd_issue;
  endproperty
  property p_cmd_done;
    (expander_req && expander_done && !wr_ctl) |=> s_cmd_finish;
  endproperty
  property p_button;
    pins_s[0] |=> flags[`STS_BUTTON];
  endproperty
  property p_fault;
    pins_s[1] |=> flags[`STS_FAULT];
  endproperty
  property p_latch;
    $changed(pins_s[2]) |=> flags[`STS_LATCH_CHG];
  endproperty
  property p_presence;
    $changed(pins_s[3]) |=> flags[`STS_PRESENCE_CHG];
  endproperty
  property p_link;
    $changed(link_active) |=> flags[`STS_LINK_CHG];
  endproperty
  property p_master;
    hotplug_irq |-> ctl[`CTL_MASTER_EN] && caps[`CAP_HOTPLUG];
  endproperty
  property p_irq_cause;
    (ctl_rd[`CTL_MASTER_EN] && flags[`STS_BUTTON] && ctl_rd[`CTL_BUTTON_EN]) |-> hotplug_irq;
  endproperty
  property p_ctl_read;
    rd_ctl_setup |=> ({prdata[15:13], prdata[11]} == 4'h0)
      && ((prdata[15:0] & ~$past(cmask)) == 16'h0000);
  endproperty
  property p_attn_absent;
    !caps[`CAP_ATTN_LIGHT] |-> attention_light == 2'h0;
  endproperty
  property p_upstream;
    UPSTREAM_PORT |-> power_light == 2'h0;
  endproperty
  property p_toggle;
    (wr_ctl && pstrb[1] && pwdata[`CTL_INTERLOCK] && caps[`CAP_INTERLOCK])
      |=> interlock_engaged != $past(interlock_engaged);
  endproperty

  a_cmd_start:    assert property (p_cmd_start)    else $error("write did not start command");
  a_cmd_done:     assert property (p_cmd_done)     else $error("command done flag missing");
  a_button:       assert property (p_button)       else $error("button flag not set");
  a_fault:        assert property (p_fault)        else $error("fault flag not set");
  a_latch:        assert property (p_latch)        else $error("latch change flag not set");
  a_presence:     assert property (p_presence)     else $error("presence flag not set");
  a_link:         assert property (p_link)         else $error("link change flag not set");
  a_master:       assert property (p_master)       else $error("irq without master enable");
  a_irq_cause:    assert property (p_irq_cause)    else $error("enabled flag without irq");
  a_ctl_read:     assert property (p_ctl_read)     else $error("masked bits read nonzero");
  a_attn_absent:  assert property (p_attn_absent)  else $error("attention light not zero");
  a_upstream:     assert property (p_upstream)     else $error("upstream power light driven");
  a_toggle:       assert property (p_toggle)       else $error("interlock did not toggle");

endmodule : slot_hotplug_control

// File: rtl/slot_hotplug_params.svh
// offsets, field positions, reset values and widths of the slot hot-plug registers
`ifndef SLOT_HOTPLUG_PARAMS_SVH
`define SLOT_HOTPLUG_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_SLOT_CAPABILITIES    12'h054
`define IDX_SLOT_CONTROL         12'h058
`define IDX_SLOT_STATUS          12'h05A
`define IDX_SLOT_CONTROL_INIT    12'h05C
`define ADDR_SLOT_CAPABILITIES   (`IDX_SLOT_CAPABILITIES * 4)
`define ADDR_SLOT_CONTROL        (`IDX_SLOT_CONTROL * 4)
`define ADDR_SLOT_STATUS         (`IDX_SLOT_STATUS * 4)
`define ADDR_SLOT_CONTROL_INIT   (`IDX_SLOT_CONTROL_INIT * 4)
`define ADDR_W                   12

// ----------------------------------------------------------------------------
// slot control fields
// ----------------------------------------------------------------------------
`define CTL_BUTTON_EN            0
`define CTL_FAULT_EN             1
`define CTL_LATCH_EN             2
`define CTL_PRESENCE_EN          3
`define CTL_CMD_INT_EN           4
`define CTL_MASTER_EN            5
`define CTL_ATTN_LO              6
`define CTL_ATTN_HI              7
`define CTL_PWRL_LO              8
`define CTL_PWRL_HI              9
`define CTL_POWER_SW             10
`define CTL_INTERLOCK            11
`define CTL_LINK_EN              12

// ----------------------------------------------------------------------------
// slot capability fields
// ----------------------------------------------------------------------------
`define CAP_BUTTON               0
`define CAP_POWER_CTL            1
`define CAP_LATCH                2
`define CAP_ATTN_LIGHT           3
`define CAP_POWER_LIGHT          4
`define CAP_HOTPLUG              6
`define CAP_INTERLOCK            17

// ----------------------------------------------------------------------------
// slot status fields
// ----------------------------------------------------------------------------
`define STS_BUTTON               0
`define STS_FAULT                1
`define STS_LATCH_CHG            2
`define STS_PRESENCE_CHG         3
`define STS_CMD_DONE             4
`define STS_LATCH_STATE          5
`define STS_PRESENCE_STATE       6
`define STS_INTERLOCK_STATE      7
`define STS_LINK_CHG             8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CAPS_RESET               32'h0000_0000
`define CTL_INIT_RESET           16'h0000
`define RDATA_RESET              32'h0000_0000
`define SYNC_STAGES              2

`endif

// File: rtl/slot_hotplug_pkg.sv
// types shared by the slot hot-plug control block
package slot_hotplug_pkg;

  // --------------------------------------------------------------------------
  // command engine states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_IDLE = 3'b001,
    CMD_XFER = 3'b010,
    CMD_DONE = 3'b100
  } cmd_state_e;

  typedef logic [15:0] half_t;

endpackage : slot_hotplug_pkg

// File: sim/slot_model.sv
// slot hardware model: expander side, answers expander transfers after a delay
`timescale 1ns/1ns
module slot_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       expander_req,
  input  wire logic [3:0] delay,
  output logic            expander_done
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_done;

  // --------------------------------------------------------------------------
  // transfer completion
  // --------------------------------------------------------------------------
  always_comb begin
    next_cnt  = 4'h0;
    next_done = 1'b0;
    if (!expander_done && expander_req) begin
      if (cnt == delay) begin
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt           <= 4'h0;
      expander_done <= 1'b0;
    end else begin
      cnt           <= next_cnt;
      expander_done <= next_done;
    end
  end
endmodule : slot_model

// File: sim/tb_top.sv
// self-checking bench of the slot hot-plug control block
`timescale 1ns/1ns
`include "slot_hotplug_params.svh"
module tb_top;
  import slot_hotplug_pkg::*;
  localparam logic [31:0] CAPS = 32'h0002_005F;
  localparam logic [15:0] INIT = 16'hF5A5;
  localparam int EN_BIT[5]  = '{0, 1, 2, 3, 12};
  localparam int STS_BIT[5] = '{0, 1, 2, 3, 8};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, d;
  logic [3:0]  pstrb, delay;
  logic        button_pin, fault_pin, latch_open_pin, presence_pin, link_active;
  logic        expander_done, expander_req, slot_power_off, interlock_engaged;
  logic        hotplug_irq, wake_event, rerr, ilk;
  logic [1:0]  attention_light, power_light, up_power_light;
  logic [15:0] e;
  int          errors, cmp_count, seed;

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

  slot_hotplug_control #(.CAPS_INIT(CAPS), .CTL_INIT(INIT), .UPSTREAM_PORT(1'b0)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .button_pin, .fault_pin, .latch_open_pin, .presence_pin,
    .link_active, .expander_done, .expander_req, .attention_light, .power_light,
    .slot_power_off, .interlock_engaged, .hotplug_irq, .wake_event);
  slot_hotplug_control #(.CAPS_INIT(CAPS), .CTL_INIT(INIT), .UPSTREAM_PORT(1'b1)) dut_up (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(),
    .pready(), .pslverr(), .button_pin, .fault_pin, .latch_open_pin, .presence_pin,
    .link_active, .expander_done, .expander_req(), .attention_light(),
    .power_light(up_power_light), .slot_power_off(), .interlock_engaged(),
    .hotplug_irq(), .wake_event());
  slot_model partner (.pclk, .presetn, .expander_req, .delay, .expander_done);

  // --------------------------------------------------------------------------
  // expectation and bus tasks
  // --------------------------------------------------------------------------
  function automatic logic [15:0] exp_ctl(input logic [15:0] v, input logic [31:0] c);
    logic [15:0] m;
    m       = 16'h1000;
    m[2:0]  = c[2:0];
    m[5:3]  = {3{c[6]}};
    m[7:6]  = {2{c[3]}};
    m[9:8]  = {2{c[4]}};
    m[10]   = c[1];
    return v & m;
  endfunction : exp_ctl

  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      print_verdict();
    end
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cmd_wait;
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADDR_SLOT_STATUS, 32'h0);
      n++;
    end while (rdat[4] !== 1'b1 && n < 40);
    `CHK(rdat[4], 1'b1)
    if (rdat[4] !== 1'b1) print_verdict();
    apb(1'b1, `ADDR_SLOT_STATUS, 32'h0000_01FF);
  endtask : cmd_wait

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #5_000_000;
    errors++;
    print_verdict();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, button_pin, fault_pin} = 6'h00;
    {latch_open_pin, presence_pin, link_active, ilk} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    delay = 4'h1;
    errors = 0;
    cmp_count = 0;
    seed = 32'hcb61afed;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_SLOT_CONTROL, 32'h0);
    `CHK(rdat, {16'h0, exp_ctl(INIT, CAPS)})
    `CHK({slot_power_off, power_light, attention_light}, INIT[10:6])
    apb(1'b0, `ADDR_SLOT_CAPABILITIES, 32'h0);
    `CHK(rdat, CAPS)
    apb(1'b0, `ADDR_SLOT_CONTROL_INIT, 32'h0);
    `CHK(rdat, {16'h0, INIT})
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    $display("test done: reset values");
    delay <= 4'hF;
    apb(1'b1, `ADDR_SLOT_CONTROL, 32'h0);
    apb(1'b0, `ADDR_SLOT_STATUS, 32'h0);
    `CHK({expander_req, rdat[4]}, 2'b10)
    cmd_wait();
    $display("test done: slow command");
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
      delay <= 4'($random(seed));
      e = exp_ctl(d[15:0], CAPS);
      ilk = ilk ^ d[11];
      apb(1'b1, `ADDR_SLOT_CONTROL, d);
      cmd_wait();
      apb(1'b0, `ADDR_SLOT_CONTROL, 32'h0);
      `CHK(rdat, {16'h0, e})
      `CHK(attention_light, e[7:6])
      `CHK(power_light, e[9:8])
      `CHK(slot_power_off, e[10])
      `CHK(interlock_engaged, ilk)
      `CHK(up_power_light, 2'b00)
    end
    $display("test done: random control writes");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `ADDR_SLOT_CONTROL, (32'h1 << EN_BIT[i]) | 32'h20);
      cmd_wait();
      `CHK(hotplug_irq, 1'b0)
      case (i)
        0: button_pin <= 1'b1;
        1: fault_pin <= 1'b1;
        2: latch_open_pin <= ~latch_open_pin;
        3: presence_pin <= ~presence_pin;
        default: link_active <= ~link_active;
      endcase
      @(posedge pclk);
      button_pin <= 1'b0;
      fault_pin  <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK({hotplug_irq, wake_event}, 2'b11)
      apb(1'b0, `ADDR_SLOT_STATUS, 32'h0);
      `CHK(rdat[STS_BIT[i]], 1'b1)
      apb(1'b1, `ADDR_SLOT_CONTROL, 32'h1 << EN_BIT[i]);
      repeat (2) @(posedge pclk);
      `CHK({hotplug_irq, wake_event}, 2'b01)
      cmd_wait();
      apb(1'b0, `ADDR_SLOT_STATUS, 32'h0);
      `CHK(rdat[8:0] & 9'h11F, 9'h000)
      `CHK(wake_event, 1'b0)
    end
    $display("test done: slot events");
    apb(1'b1, `ADDR_SLOT_CONTROL, 32'h30);
    repeat (30) @(posedge pclk);
    `CHK({hotplug_irq, wake_event}, 2'b10)
    cmd_wait();
    @(negedge pclk);
    `CHK(hotplug_irq, 1'b0)
    $display("test done: command interrupt");
    apb(1'b1, `ADDR_SLOT_CAPABILITIES, 32'h0);
    apb(1'b1, `ADDR_SLOT_CONTROL, 32'h0000_FFFF);
    cmd_wait();
    apb(1'b0, `ADDR_SLOT_CONTROL, 32'h0);
    `CHK(rdat, 32'h0000_1000)
    `CHK(attention_light, 2'b00)
    `CHK(power_light, 2'b00)
    $display("test done: absent capabilities");
    print_verdict();
  end
endmodule : tb_top
